//--- hdl/amsc_pkg.sv
// Shared constants, widths and types of the asynchronous memory strobe controller.
package amsc_pkg;
   localparam int NUM_CE = 4;
   localparam int CE_SEL_W = 2;
   localparam int CNT_W = 6;
   localparam int WIDE_DATA_W = 64;
   localparam int WIDE_BE_W = 8;
   localparam int WIDE_ADDR_MSB = 22;
   localparam int WIDE_ADDR_LSB = 3;
   localparam int NARROW_DATA_W = 16;
   localparam int NARROW_BE_W = 2;
   localparam int NARROW_ADDR_MSB = 20;
   localparam int NARROW_ADDR_LSB = 1;
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int MEM_CLK_PERIOD_NS = 40;
   localparam int MEM_CLK_HALF_CYC = MEM_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
   localparam int DIV_W = 4;
   localparam logic [CNT_W-1:0] READY_WINDOW = 6'h02;

   typedef struct packed {
      logic [CNT_W-1:0] readSetup;
      logic [CNT_W-1:0] readStrobe;
      logic [CNT_W-1:0] readHold;
      logic [CNT_W-1:0] writeSetup;
      logic [CNT_W-1:0] writeStrobe;
      logic [CNT_W-1:0] writeHold;
   } amsc_timing_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_SETUP = 3'b010,
      ST_STROBE = 3'b011,
      ST_HOLD = 3'b100
   } amsc_state_t;
endpackage

//--- hdl/amsc_async_mem_ctrl.sv
// Asynchronous memory cycle sequencer with setup, strobe and hold phases.
`timescale 1ns/10ps
module amsc_async_mem_ctrl #(
   parameter bit WIDE_PORT = 1'b1
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire amsc_pkg::amsc_timing_t [amsc_pkg::NUM_CE-1:0] ceTiming,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [amsc_pkg::CE_SEL_W-1:0] reqSpace,
   input wire logic [(WIDE_PORT ? amsc_pkg::WIDE_ADDR_MSB : amsc_pkg::NARROW_ADDR_MSB):
                     (WIDE_PORT ? amsc_pkg::WIDE_ADDR_LSB : amsc_pkg::NARROW_ADDR_LSB)] reqAddr,
   input wire logic [(WIDE_PORT ? amsc_pkg::WIDE_BE_W : amsc_pkg::NARROW_BE_W)-1:0] reqByteEn,
   input wire logic [(WIDE_PORT ? amsc_pkg::WIDE_DATA_W : amsc_pkg::NARROW_DATA_W)-1:0] reqWdata,
   output logic reqReady,
   output logic rspValid,
   output logic [(WIDE_PORT ? amsc_pkg::WIDE_DATA_W : amsc_pkg::NARROW_DATA_W)-1:0] rspRdata,
   output logic mem_clk_primary,
   output logic [amsc_pkg::NUM_CE-1:0] chip_select_n,
   output logic [(WIDE_PORT ? amsc_pkg::WIDE_BE_W : amsc_pkg::NARROW_BE_W)-1:0] byte_lane_enable_n,
   output logic [(WIDE_PORT ? amsc_pkg::WIDE_ADDR_MSB : amsc_pkg::NARROW_ADDR_MSB):
                 (WIDE_PORT ? amsc_pkg::WIDE_ADDR_LSB : amsc_pkg::NARROW_ADDR_LSB)] word_addr,
   output logic output_enable_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic [(WIDE_PORT ? amsc_pkg::WIDE_DATA_W : amsc_pkg::NARROW_DATA_W)-1:0] memDataOut,
   output logic memDataOe,
   input wire logic [(WIDE_PORT ? amsc_pkg::WIDE_DATA_W : amsc_pkg::NARROW_DATA_W)-1:0] memDataIn,
   input wire logic mem_ready_in
);
   localparam int DW = WIDE_PORT ? amsc_pkg::WIDE_DATA_W : amsc_pkg::NARROW_DATA_W;
   localparam int BW = WIDE_PORT ? amsc_pkg::WIDE_BE_W : amsc_pkg::NARROW_BE_W;
   localparam int AH = WIDE_PORT ? amsc_pkg::WIDE_ADDR_MSB : amsc_pkg::NARROW_ADDR_MSB;
   localparam int AL = WIDE_PORT ? amsc_pkg::WIDE_ADDR_LSB : amsc_pkg::NARROW_ADDR_LSB;
   localparam int CW = amsc_pkg::CNT_W;
   localparam int NCE = amsc_pkg::NUM_CE;
   localparam logic [amsc_pkg::DIV_W-1:0] DIV_LAST = amsc_pkg::DIV_W'(amsc_pkg::MEM_CLK_HALF_CYC - 1);

   // A programmed count of zero is treated as one period, so every phase lasts at least once.
   function automatic logic [CW-1:0] loadCount(input logic [CW-1:0] periods);
      loadCount = (periods == '0) ? '0 : periods - CW'(1);
   endfunction

   // Memory clock divider.
   logic [amsc_pkg::DIV_W-1:0] divCnt_r, divCnt_nxt;
   logic memClk_r, memClk_nxt;
   logic riseTick;

   always_comb begin
      riseTick = (divCnt_r == DIV_LAST) && !memClk_r;
      divCnt_nxt = divCnt_r + amsc_pkg::DIV_W'(1);
      memClk_nxt = memClk_r;
      if (divCnt_r == DIV_LAST) begin
         divCnt_nxt = '0;
         memClk_nxt = !memClk_r;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         divCnt_r <= '0;
         memClk_r <= 1'b0;
      end else begin
         divCnt_r <= divCnt_nxt;
         memClk_r <= memClk_nxt;
      end
   end

   // Pin synchronisers; the first stage is read only by the second.
   logic rdyMeta_r, rdySync_r;
   logic [DW-1:0] dataMeta_r, dataSync_r;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdyMeta_r <= 1'b1;
         rdySync_r <= 1'b1;
         dataMeta_r <= '0;
         dataSync_r <= '0;
      end else begin
         rdyMeta_r <= mem_ready_in;
         rdySync_r <= rdyMeta_r;
         dataMeta_r <= memDataIn;
         dataSync_r <= dataMeta_r;
      end
   end

   // Access sequencer.
   amsc_pkg::amsc_state_t state_r, state_nxt;
   amsc_pkg::amsc_timing_t timing_r, timing_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic isWrite_r, isWrite_nxt;
   logic [amsc_pkg::CE_SEL_W-1:0] space_r, space_nxt;
   logic [AH:AL] addr_r, addr_nxt;
   logic [BW-1:0] be_r, be_nxt;
   logic [DW-1:0] wdata_r, wdata_nxt;
   logic reqReady_r, reqReady_nxt;
   logic rspValid_r, rspValid_nxt;
   logic [DW-1:0] rdata_r, rdata_nxt;
   logic [NCE-1:0] cs_r, cs_nxt;
   logic [BW-1:0] beOut_r, beOut_nxt;
   logic [AH:AL] addrOut_r, addrOut_nxt;
   logic oeN_r, oeN_nxt;
   logic reN_r, reN_nxt;
   logic weN_r, weN_nxt;
   logic [DW-1:0] dOut_r, dOut_nxt;
   logic dOe_r, dOe_nxt;

   always_comb begin
      state_nxt = state_r;
      timing_nxt = timing_r;
      cnt_nxt = cnt_r;
      isWrite_nxt = isWrite_r;
      space_nxt = space_r;
      addr_nxt = addr_r;
      be_nxt = be_r;
      wdata_nxt = wdata_r;
      reqReady_nxt = reqReady_r;
      rspValid_nxt = 1'b0;
      rdata_nxt = rdata_r;
      cs_nxt = cs_r;
      beOut_nxt = beOut_r;
      addrOut_nxt = addrOut_r;
      oeN_nxt = oeN_r;
      reN_nxt = reN_r;
      weN_nxt = weN_r;
      dOut_nxt = dOut_r;
      dOe_nxt = dOe_r;
      unique case (state_r)
         amsc_pkg::ST_IDLE: begin
            if (reqValid && reqReady_r) begin
               timing_nxt = ceTiming[reqSpace];
               isWrite_nxt = reqWrite;
               space_nxt = reqSpace;
               addr_nxt = reqAddr;
               be_nxt = reqByteEn;
               wdata_nxt = reqWdata;
               reqReady_nxt = 1'b0;
               state_nxt = amsc_pkg::ST_START;
            end
         end
         amsc_pkg::ST_START: begin
            // Selects are launched on a memory clock rise so setup counts whole periods.
            if (riseTick) begin
               cs_nxt = ~(NCE'(1) << space_r);
               beOut_nxt = ~be_r;
               addrOut_nxt = addr_r;
               oeN_nxt = isWrite_r;
               dOut_nxt = wdata_r;
               dOe_nxt = isWrite_r;
               cnt_nxt = isWrite_r ? loadCount(timing_r.writeSetup) :
                                     loadCount(timing_r.readSetup);
               state_nxt = amsc_pkg::ST_SETUP;
            end
         end
         amsc_pkg::ST_SETUP: begin
            if (riseTick) begin
               if (cnt_r == '0) begin
                  reN_nxt = isWrite_r;
                  weN_nxt = !isWrite_r;
                  cnt_nxt = isWrite_r ? loadCount(timing_r.writeStrobe) :
                                        loadCount(timing_r.readStrobe);
                  state_nxt = amsc_pkg::ST_STROBE;
               end else begin
                  cnt_nxt = cnt_r - CW'(1);
               end
            end
         end
         amsc_pkg::ST_STROBE: begin
            if (riseTick) begin
               if (cnt_r == '0) begin
                  reN_nxt = 1'b1;
                  weN_nxt = 1'b1;
                  if (!isWrite_r) begin
                     rdata_nxt = dataSync_r;
                  end
                  cnt_nxt = isWrite_r ? loadCount(timing_r.writeHold) :
                                        loadCount(timing_r.readHold);
                  state_nxt = amsc_pkg::ST_HOLD;
               end else if (cnt_r == amsc_pkg::READY_WINDOW && !rdySync_r) begin
                  // Parking at the window edge makes the end fall two periods after ready.
                  cnt_nxt = cnt_r;
               end else begin
                  cnt_nxt = cnt_r - CW'(1);
               end
            end
         end
         amsc_pkg::ST_HOLD: begin
            if (riseTick) begin
               if (cnt_r == '0) begin
                  cs_nxt = '1;
                  oeN_nxt = 1'b1;
                  dOe_nxt = 1'b0;
                  rspValid_nxt = 1'b1;
                  reqReady_nxt = 1'b1;
                  state_nxt = amsc_pkg::ST_IDLE;
               end else begin
                  cnt_nxt = cnt_r - CW'(1);
               end
            end
         end
         default: begin
            state_nxt = amsc_pkg::ST_IDLE;
            reqReady_nxt = 1'b1;
            cs_nxt = '1;
            oeN_nxt = 1'b1;
            reN_nxt = 1'b1;
            weN_nxt = 1'b1;
            dOe_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= amsc_pkg::ST_IDLE;
         timing_r <= '0;
         cnt_r <= '0;
         isWrite_r <= 1'b0;
         space_r <= '0;
         addr_r <= '0;
         be_r <= '0;
         wdata_r <= '0;
         reqReady_r <= 1'b1;
         rspValid_r <= 1'b0;
         rdata_r <= '0;
         cs_r <= '1;
         beOut_r <= '1;
         addrOut_r <= '0;
         oeN_r <= 1'b1;
         reN_r <= 1'b1;
         weN_r <= 1'b1;
         dOut_r <= '0;
         dOe_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         timing_r <= timing_nxt;
         cnt_r <= cnt_nxt;
         isWrite_r <= isWrite_nxt;
         space_r <= space_nxt;
         addr_r <= addr_nxt;
         be_r <= be_nxt;
         wdata_r <= wdata_nxt;
         reqReady_r <= reqReady_nxt;
         rspValid_r <= rspValid_nxt;
         rdata_r <= rdata_nxt;
         cs_r <= cs_nxt;
         beOut_r <= beOut_nxt;
         addrOut_r <= addrOut_nxt;
         oeN_r <= oeN_nxt;
         reN_r <= reN_nxt;
         weN_r <= weN_nxt;
         dOut_r <= dOut_nxt;
         dOe_r <= dOe_nxt;
      end
   end

   // Byte enables and address keep their last value between accesses; chip selects, output enable and data enable idle.
   always_comb begin
      reqReady = reqReady_r;
      rspValid = rspValid_r;
      rspRdata = rdata_r;
      mem_clk_primary = memClk_r;
      chip_select_n = cs_r;
      byte_lane_enable_n = beOut_r;
      word_addr = addrOut_r;
      output_enable_n = oeN_r;
      read_strobe_n = reN_r;
      write_strobe_n = weN_r;
      memDataOut = dOut_r;
      memDataOe = dOe_r;
   end
endmodule

//--- dv/amsc_assertions.sv
// Port-level assertions for the asynchronous memory strobe controller.
`timescale 1ns/10ps
module amsc_assertions (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic mem_clk_primary,
   input wire logic [amsc_pkg::NUM_CE-1:0] chip_select_n,
   input wire logic output_enable_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic memDataOe,
   input wire logic mem_ready_in
);
   logic [4:0] lowCnt_r, lowCnt_nxt, strbCnt_r, strbCnt_nxt;
   logic idle;
   assign idle = read_strobe_n & write_strobe_n;
   always_comb begin
      lowCnt_nxt = mem_ready_in ? 5'h00 : lowCnt_r + 5'(lowCnt_r != 5'h1f);
      strbCnt_nxt = idle ? 5'h00 : strbCnt_r + 5'(strbCnt_r != 5'h1f);
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt_r <= 5'h00;
         strbCnt_r <= 5'h00;
      end else begin
         lowCnt_r <= lowCnt_nxt;
         strbCnt_r <= strbCnt_nxt;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_selHeld; $stable(chip_select_n)[*4]; endsequence
   property p_edge; $changed(idle) |-> $rose(mem_clk_primary); endproperty
   property p_rdSel; !read_strobe_n |-> !output_enable_n && write_strobe_n && !(&chip_select_n);
   endproperty
   property p_wrSel; !write_strobe_n |-> output_enable_n && memDataOe && !(&chip_select_n);
   endproperty
   property p_rdSetup; $fell(read_strobe_n) |-> !$past(output_enable_n, 4); endproperty
   property p_wrSetup; $fell(write_strobe_n) |-> $past(memDataOe, 4); endproperty
   property p_rdHold; $rose(read_strobe_n) |-> s_selHeld and (!output_enable_n)[*4]; endproperty
   property p_wrHold; $rose(write_strobe_n) |-> s_selHeld and memDataOe[*4]; endproperty
   // Only long strobes qualify: a count of two or less never reaches the ready window.
   property p_stretch; lowCnt_r > 5'h0f && strbCnt_r > 5'h0b && !idle |=> !idle; endproperty
   a_edge: assert property (p_edge) else $error("strobe moved off clock rise");
   a_rdSel: assert property (p_rdSel) else $error("read strobe without selects");
   a_wrSel: assert property (p_wrSel) else $error("write strobe without selects");
   a_rdSetup: assert property (p_rdSetup) else $error("read setup short");
   a_wrSetup: assert property (p_wrSetup) else $error("write setup short");
   a_rdHold: assert property (p_rdHold) else $error("read hold short");
   a_wrHold: assert property (p_wrHold) else $error("write hold short");
   a_stretch: assert property (p_stretch) else $error("strobe ended while not ready");
endmodule
bind amsc_async_mem_ctrl amsc_assertions u_amsc_assertions (
   .clk_sys(clk_sys),
   .reset_n(reset_n),
   .mem_clk_primary(mem_clk_primary),
   .chip_select_n(chip_select_n),
   .output_enable_n(output_enable_n),
   .read_strobe_n(read_strobe_n),
   .write_strobe_n(write_strobe_n),
   .memDataOe(memDataOe),
   .mem_ready_in(mem_ready_in)
);

//--- dv/amsc_sram_model.sv
// Behavioural asynchronous SRAM that can hold its ready line low.
`timescale 1ns/10ps
module amsc_sram_model (
   input wire logic clk_sys,
   input wire logic slowMode,
   input wire logic [3:0] chip_select_n,
   input wire logic [20:1] word_addr,
   input wire logic output_enable_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [15:0] memDataOut,
   output logic [15:0] memDataIn = 16'h0000,
   output logic mem_ready_in = 1'b1
);
   logic [15:0] mem [16];
   int waitCnt = 0;
   always @(posedge write_strobe_n)
      if (chip_select_n != 4'hf)
         mem[word_addr[4:1]] = memDataOut;
   always @(posedge clk_sys) begin
      // A released bus toggles, so stale data never passes for a read.
      if (chip_select_n != 4'hf && !output_enable_n)
         memDataIn <= mem[word_addr[4:1]];
      else
         memDataIn <= ~memDataIn;
      waitCnt <= (read_strobe_n & write_strobe_n) ? 0 : waitCnt + 1;
      mem_ready_in <= !(slowMode && !(read_strobe_n & write_strobe_n) && waitCnt < 23);
   end
endmodule

//--- dv/amsc_async_mem_ctrl_tb.sv
// Self-checking bench for the narrow memory strobe controller.
`timescale 1ns/10ps
module amsc_async_mem_ctrl_tb;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic slowMode = 1'b0;
   logic [1:0] reqSpace = 2'h0;
   logic [1:0] reqByteEn = 2'h0;
   logic [20:1] reqAddr = 20'h0_0000;
   logic [15:0] reqWdata = 16'h0000;
   amsc_pkg::amsc_timing_t [amsc_pkg::NUM_CE-1:0] ceTiming;
   logic reqReady, rspValid, mem_clk_primary, output_enable_n, read_strobe_n;
   logic write_strobe_n, memDataOe, mem_ready_in;
   logic [15:0] rspRdata, memDataOut, memDataIn;
   logic [3:0] chip_select_n;
   logic [1:0] byte_lane_enable_n;
   logic [20:1] word_addr;
   int errCount = 0;
   int nChecks = 0;
   always #5 clk_sys = ~clk_sys;
   amsc_async_mem_ctrl #(.WIDE_PORT(1'b0)) u_amsc_async_mem_ctrl (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .ceTiming(ceTiming),
      .reqValid(reqValid),
      .reqWrite(reqWrite),
      .reqSpace(reqSpace),
      .reqAddr(reqAddr),
      .reqByteEn(reqByteEn),
      .reqWdata(reqWdata),
      .reqReady(reqReady),
      .rspValid(rspValid),
      .rspRdata(rspRdata),
      .mem_clk_primary(mem_clk_primary),
      .chip_select_n(chip_select_n),
      .byte_lane_enable_n(byte_lane_enable_n),
      .word_addr(word_addr),
      .output_enable_n(output_enable_n),
      .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n),
      .memDataOut(memDataOut),
      .memDataOe(memDataOe),
      .memDataIn(memDataIn),
      .mem_ready_in(mem_ready_in)
   );
   amsc_sram_model u_amsc_sram_model (
      .clk_sys(clk_sys),
      .slowMode(slowMode),
      .chip_select_n(chip_select_n),
      .word_addr(word_addr),
      .output_enable_n(output_enable_n),
      .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n),
      .memDataOut(memDataOut),
      .memDataIn(memDataIn),
      .mem_ready_in(mem_ready_in)
   );
   task automatic testDone();
      $display("checks %0d, mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chkVal(input logic [19:0] got, input logic [19:0] exp);
      nChecks++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chkCnt(input int got, input int exp);
      nChecks++;
      if (got != exp) begin
         errCount++;
         $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask
   function automatic int eff(input int c);
      return (c == 0) ? 1 : c;
   endfunction
   task automatic access(input logic wr, input logic slw, input logic [1:0] sp,
                         input logic [15:0] d, input int s, input int t, input int h,
                         input int x);
      int n = 0;
      int cS = 0;
      int cT = 0;
      int cH = 0;
      logic stb;
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqWrite <= wr;
      slowMode <= slw;
      reqSpace <= sp;
      reqAddr <= 20'(sp);
      reqByteEn <= {1'b1, sp[0]};
      reqWdata <= d;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      while (n < 1000 && rspValid !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         n++;
         stb = wr ? write_strobe_n : read_strobe_n;
         if (rspValid !== 1'b1 && stb === 1'b0) begin
            cT++;
            if (cT == 1) begin
               chkVal(20'({chip_select_n, byte_lane_enable_n, output_enable_n, memDataOe}),
                      20'({~(4'h1 << sp), ~{1'b1, sp[0]}, wr, wr}));
               chkVal(20'(word_addr), 20'(sp));
               chkVal(20'(reqReady), 20'h0_0000);
               if (wr)
                  chkVal(20'(memDataOut), 20'(d));
            end
         end else if (rspValid !== 1'b1 && chip_select_n !== 4'hf) begin
            if (cT == 0)
               cS++;
            else
               cH++;
         end
      end
      if (n == 1000) begin
         $display("wrong value at %0t: access never finished", $time);
         errCount++;
         testDone();
      end
      chkCnt(cS, 4 * s);
      chkCnt(cH, 4 * h);
      if (x > 0)
         chkCnt(int'(cT > 4 * t), 1);
      chkCnt(cT, 4 * (t + x));
      chkVal(20'({reqReady, rspValid, chip_select_n}), 20'h0_003f);
      if (!wr)
         chkVal(20'(rspRdata), 20'(d));
      @(posedge clk_sys);
      #1;
      chkVal(20'(rspValid), 20'h0_0000);
   endtask
   initial begin
      for (int i = 0; i < 4; i++)
         ceTiming[i] <= '{6'(i), 6'(i + 1), 6'(2 * i), 6'(3 - i), 6'(i + 2), 6'(i)};
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      chkVal(20'({reqReady, rspValid, chip_select_n, output_enable_n, read_strobe_n,
                  write_strobe_n, memDataOe}), 20'h0_02fe);
      $display("reset test done");
      // Zero counts in space zero exercise the count-of-one floor.
      for (int i = 0; i < 4; i++) begin
         access(1'b1, 1'b0, 2'(i), 16'ha5c0 + 16'(i),
                eff(3 - i), eff(i + 2), eff(i), 0);
         access(1'b0, 1'b0, 2'(i), 16'ha5c0 + 16'(i),
                eff(i), eff(i + 1), eff(2 * i), 0);
         $display("space %0d test done", i);
      end
      // A strobe of two periods never reaches the ready window, so a low ready is ignored.
      access(1'b1, 1'b1, 2'h0, 16'ha5c0, 3, 2, 1, 0);
      // Ready is low for 23 clocks from the strobe fall; after two flops it is first seen
      // high at the seventh rise, so the strobe ends two rises later, five periods late.
      access(1'b0, 1'b1, 2'h3, 16'ha5c3, 3, 4, 6, 5);
      $display("stretch test done");
      testDone();
   end
endmodule
